/* design/iist_top.sv */
// Purpose: Decide event points and status snapshots of the bus block
// Assumes: Software marks master ownership before each start
// Notes: Watches the lines only; bit generation lives elsewhere
//
// Chosen here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module iist_top
    import iist_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    // Bus lines, receive side
    input  wire logic              sclIn,
    input  wire logic              sdaIn,
    // Event outputs
    output logic                   busEventRequest,
    output logic                   irq,
    // AXI4-Lite write address
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);
    // Line watcher
    iist_edges_s edges;          // Synchronised line events
    iist_bus_watch u_watch (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .sclIn   (sclIn),
        .sdaIn   (sdaIn),
        .edges   (edges)
    );
    // Software state
    logic [2:0]   ctrl_q;        // Wait select, stop enable, master
    logic         intStat_q;     // Sticky event flag
    logic         intMask_q;     // Event flag enable
    iist_status_s status_q;      // Snapshot seen by software
    wire waitSel   = ctrl_q[CTRL_WAIT_BIT];  // 0 eighth, 1 ninth
    wire stopEvtEn = ctrl_q[CTRL_SPIE_BIT];  // Stop raises event
    wire mstCtrl   = ctrl_q[CTRL_MST_BIT];   // We own the next start
    // Transfer state
    iist_phase_e phase_q;        // Idle, address or data byte
    logic [3:0]  bitCnt_q;       // Clock rises within the byte
    logic [7:0]  shift_q;        // Bits of the current byte
    logic        ack_q;          // Ack seen on ninth clock
    logic        mst_q;          // Master for this transfer
    logic        exc_q;          // Extension code received
    logic        comm_q;         // In communication
    logic        trc_q;          // Transmitting
    logic        pend_q;         // Snapshot taken, pulse next
    logic        req_q;          // Event request pulse
    // Byte position decode
    wire inAddr = (phase_q == PH_ADDR);
    wire inData = (phase_q == PH_DATA);
    wire at8    = edges.sclFall && (bitCnt_q == DATA_CLOCKS);
    wire at9    = edges.sclFall && (bitCnt_q == ACK_CLOCK);
    wire extNow = isExtCode(shift_q[7:1]);
    // Direction bit read 0 means the master sends
    wire trcNow = mst_q ? ~shift_q[0] : shift_q[0];
    // Slave sees an extension code: event at eighth clock
    wire slvExt8 = inAddr & at8 & ~mst_q & extNow;
    // Slave extension with ninth-clock wait: second event
    wire slvExt9 = inAddr & at9 & ~mst_q & exc_q & waitSel;
    // Master address byte: event after its acknowledge
    wire mstAddr9 = inAddr & at9 & mst_q;
    // Data events follow the live wait select, so software can move the last one
    wire data8 = inData & at8 & comm_q & ~waitSel;
    wire data9 = inData & at9 & comm_q & waitSel;
    // Byte events always raise; stop only when enabled
    wire byteEvt = slvExt8 | slvExt9 | mstAddr9 | data8 | data9;
    wire evtD    = byteEvt | (edges.stop & stopEvtEn);
    wire snapEn  = byteEvt | edges.stop;
    // Start shown on address events only; ack only after the ninth clock
    iist_status_s statByte;      // Byte-event snapshot
    iist_status_s statD;         // Selected snapshot
    assign statByte.master    = mst_q;
    assign statByte.arbLost   = 1'b0;
    assign statByte.extCode   = (inAddr & ~mst_q) | exc_q;
    assign statByte.addrMatch = 1'b0;
    assign statByte.transmit  = slvExt8 ? trcNow : trc_q;
    assign statByte.ackSeen   = at9 & ack_q;
    assign statByte.startSeen = inAddr;
    assign statByte.stopSeen  = 1'b0;
    // Stop wins the slot and clears every other flag
    assign statD = edges.stop ? iist_status_s'(STOP_STATUS) : statByte;
    // Phase moves on start, address completion and stop
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= PH_IDLE;
        end else if (edges.stop) begin
            phase_q <= PH_IDLE;
        end else if (edges.start) begin
            phase_q <= PH_ADDR;
        end else begin
            unique case (phase_q)
                PH_ADDR: phase_q <= at9 ? PH_DATA : PH_ADDR;
                PH_IDLE, PH_DATA: phase_q <= phase_q;
                default: phase_q <= PH_IDLE;
            endcase
        end
    end
    // Clock count wraps to 1 on the rise after the ack clock
    wire [3:0] cntNext = (bitCnt_q == ACK_CLOCK) ? 4'h1 : bitCnt_q + 4'h1;
    wire       dataRise = edges.sclRise & (cntNext <= DATA_CLOCKS);
    wire       ackRise  = edges.sclRise & (cntNext == ACK_CLOCK);
    // Count clocks only inside a transfer
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bitCnt_q <= 4'h0;
        end else if (edges.start || edges.stop) begin
            bitCnt_q <= 4'h0;
        end else if (edges.sclRise && phase_q != PH_IDLE) begin
            bitCnt_q <= cntNext;
        end
    end
    // Bits one to eight MSB first; low line on the ninth is an ack
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            shift_q <= 8'h00;
            ack_q   <= 1'b0;
        end else if (phase_q != PH_IDLE) begin
            if (dataRise) shift_q <= {shift_q[6:0], edges.sda};
            if (ackRise) ack_q <= ~edges.sda;
        end
    end
    // Master ownership is latched at each start
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mst_q <= 1'b0;
        end else if (edges.start) begin
            mst_q <= mstCtrl;
        end else if (edges.stop) begin
            mst_q <= 1'b0;
        end
    end
    // Extension and communication re-judged on every restart
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            exc_q  <= 1'b0;
            comm_q <= 1'b0;
        end else if (edges.start || edges.stop) begin
            exc_q  <= 1'b0;
            comm_q <= 1'b0;
        end else if (inAddr && at8) begin
            exc_q  <= extNow;
            comm_q <= mst_q | extNow;
        end
    end
    // Direction fixed by the address byte
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            trc_q <= 1'b0;
        end else if (inAddr && at8) begin
            trc_q <= trcNow;
        end
    end
    // Snapshot lands one cycle before the request pulse
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= iist_status_s'(STATUS_RST);
        end else if (snapEn) begin
            status_q <= statD;
        end
    end
    // Delay keeps the pulse after the snapshot is stable
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pend_q <= 1'b0;
            req_q  <= 1'b0;
        end else begin
            pend_q <= evtD;
            req_q  <= pend_q;
        end
    end
    assign busEventRequest = req_q;
    // AXI4-Lite write side
    logic              awReady_q;  // Address slot free
    logic              wReady_q;   // Data slot free
    logic              awHeld_q;   // Address captured
    logic              wHeld_q;    // Data captured
    logic [ADDR_W-1:0] awAddr_q;   // Captured write address
    logic [7:0]        wData_q;    // Captured low byte
    logic              wStrb_q;    // Low lane enabled
    logic              bValid_q;   // Response pending
    logic [1:0]        bResp_q;    // Response code
    wire awTake  = s_axi_awvalid & awReady_q;
    wire wTake   = s_axi_wvalid & wReady_q;
    wire doWrite = awHeld_q & wHeld_q & ~bValid_q;
    wire bDone   = bValid_q & s_axi_bready;
    // Write decode on the captured address
    wire wrCtrl  = doWrite & (awAddr_q == ADDR_W'(CTRL_OFS));
    wire wrIntSt = doWrite & (awAddr_q == ADDR_W'(INTST_OFS));
    wire wrMask  = doWrite & (awAddr_q == ADDR_W'(INTMSK_OFS));
    wire wrStat  = doWrite & (awAddr_q == ADDR_W'(STATUS_OFS));
    wire wrHit   = wrCtrl | wrIntSt | wrMask | wrStat;
    // Address and data are taken in either order
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            awReady_q <= 1'b1;
            awHeld_q  <= 1'b0;
            awAddr_q  <= '0;
        end else if (awTake) begin
            awReady_q <= 1'b0;
            awHeld_q  <= 1'b1;
            awAddr_q  <= s_axi_awaddr;
        end else if (doWrite) begin
            awHeld_q  <= 1'b0;
        end else if (bDone) begin
            awReady_q <= 1'b1;
        end
    end
    // Only the low lane carries register bits
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wReady_q <= 1'b1;
            wHeld_q  <= 1'b0;
            wData_q  <= 8'h00;
            wStrb_q  <= 1'b0;
        end else if (wTake) begin
            wReady_q <= 1'b0;
            wHeld_q  <= 1'b1;
            wData_q  <= s_axi_wdata[7:0];
            wStrb_q  <= s_axi_wstrb[0];
        end else if (doWrite) begin
            wHeld_q  <= 1'b0;
        end else if (bDone) begin
            wReady_q <= 1'b1;
        end
    end
    // Response after both halves; unmapped gets an error
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bValid_q <= 1'b0;
            bResp_q  <= RESP_OKAY;
        end else if (doWrite) begin
            bValid_q <= 1'b1;
            bResp_q  <= wrHit ? RESP_OKAY : RESP_SLVERR;
        end else if (bDone) begin
            bValid_q <= 1'b0;
        end
    end
    // Control and mask writes; status is read only
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q    <= CTRL_RST;
            intMask_q <= MASK_RST;
        end else if (wStrb_q) begin
            if (wrCtrl) ctrl_q <= wData_q[2:0];
            if (wrMask) intMask_q <= wData_q[0];
        end
    end
    // Sticky flag: a new event beats a same-cycle clear
    wire intClr = wrIntSt & wStrb_q & wData_q[0];
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            intStat_q <= 1'b0;
        end else begin
            intStat_q <= (intStat_q & ~intClr) | req_q;
        end
    end
    // Level interrupt, registered so the pin is a flop
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= intStat_q & intMask_q;
        end
    end
    // AXI4-Lite read side
    logic        arReady_q;      // Read slot free
    logic        rValid_q;       // Read data pending
    logic [31:0] rData_q;        // Read data
    logic [1:0]  rResp_q;        // Read response
    wire arTake = s_axi_arvalid & arReady_q;
    wire rDone  = rValid_q & s_axi_rready;
    // Read mux; upper bits read as zero
    wire rdCtrl  = (s_axi_araddr == ADDR_W'(CTRL_OFS));
    wire rdStat  = (s_axi_araddr == ADDR_W'(STATUS_OFS));
    wire rdIntSt = (s_axi_araddr == ADDR_W'(INTST_OFS));
    wire rdMask  = (s_axi_araddr == ADDR_W'(INTMSK_OFS));
    wire rdHit   = rdCtrl | rdStat | rdIntSt | rdMask;
    wire [31:0] rdMux = rdCtrl  ? {29'h0, ctrl_q} :
                        rdStat  ? {24'h0, status_q} :
                        rdIntSt ? {31'h0, intStat_q} :
                        rdMask  ? {31'h0, intMask_q} : 32'h0;
    // One read in flight; answer one cycle after taking
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            arReady_q <= 1'b1;
            rValid_q  <= 1'b0;
            rData_q   <= 32'h0;
            rResp_q   <= RESP_OKAY;
        end else if (arTake) begin
            arReady_q <= 1'b0;
            rValid_q  <= 1'b1;
            rData_q   <= rdMux;
            rResp_q   <= rdHit ? RESP_OKAY : RESP_SLVERR;
        end else if (rDone) begin
            arReady_q <= 1'b1;
            rValid_q  <= 1'b0;
        end
    end
    // Port hookup from flops
    assign s_axi_awready = awReady_q;
    assign s_axi_wready  = wReady_q;
    assign s_axi_bvalid  = bValid_q;
    assign s_axi_bresp   = bResp_q;
    assign s_axi_arready = arReady_q;
    assign s_axi_rvalid  = rValid_q;
    assign s_axi_rdata   = rData_q;
    assign s_axi_rresp   = rResp_q;
endmodule

/* design/iist_pkg.sv */
// Purpose: Shared constants and types for the bus event timing block
// Assumes: 32-bit AXI4-Lite register port, 8-bit status snapshot
// Notes: Operation summary below, one line per behaviour
// Operation
// - Byte events always; stop event only if enabled
// - Master address event reads 1000X110B
// - Master eighth-clock data events read 1000X000B
// - Master ninth-clock data events read 1000X100B
// - Last master data event reads 1000XX00B
// - After stop, status reads 00000001B
// - Master extension code event reads 1010X110B
// - Master extension, ninth clock: 1010X100B, 1010XX00B
// - Master extension, eighth clock: 1010X000B
// - Slave extension: 0010X010B, then 0010X000B data
// - Slave extension, ninth clock: extra 0010X110B event
// - Extension code means in communication; repeats on restart
// - Wait select 0 eighth clock, 1 ninth clock
package iist_pkg;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS    = 8'h00;
    localparam logic [7:0] STATUS_OFS  = 8'h04;
    localparam logic [7:0] INTST_OFS   = 8'h08;
    localparam logic [7:0] INTMSK_OFS  = 8'h0c;

    // Control field positions
    localparam int CTRL_WAIT_BIT = 0;
    localparam int CTRL_SPIE_BIT = 1;
    localparam int CTRL_MST_BIT  = 2;

    // Reset values
    localparam logic [2:0] CTRL_RST   = 3'h0;
    localparam logic       MASK_RST   = 1'b0;
    localparam logic [7:0] STATUS_RST = 8'h00;

    // Status shown after a stop
    localparam logic [7:0] STOP_STATUS = 8'h01;

    // Bit positions of a byte on the wire
    localparam logic [3:0] DATA_CLOCKS = 4'h8;
    localparam logic [3:0] ACK_CLOCK   = 4'h9;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Snapshot layout, bit 7 down to bit 0
    typedef struct packed {
        logic master;
        logic arbLost;
        logic extCode;
        logic addrMatch;
        logic transmit;
        logic ackSeen;
        logic startSeen;
        logic stopSeen;
    } iist_status_s;

    // Line events seen by the watcher
    typedef struct packed {
        logic sclRise;
        logic sclFall;
        logic start;
        logic stop;
        logic sda;
    } iist_edges_s;

    // Transfer phase
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_ADDR,
        PH_DATA
    } iist_phase_e;

    // Extension codes: address field 0000xxx or 1111xxx
    function automatic logic isExtCode(input logic [6:0] addr);
        return (addr[6:3] == 4'h0) || (addr[6:3] == 4'hf);
    endfunction

endpackage

/* design/iist_bus_watch.sv */
// Purpose: Synchronise the two bus lines and report their events
// Assumes: Lines are slow against the system clock
// Notes: Start and stop need the clock line steady high
`timescale 1ns/1ps
module iist_bus_watch
    import iist_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // Bus lines
    input  wire logic        sclIn,
    input  wire logic        sdaIn,
    // Line events
    output iist_edges_s      edges
);

    logic [1:0] sclSync_q;   // Synchroniser for clock line
    logic [1:0] sdaSync_q;   // Synchroniser for data line
    logic       sclLast_q;   // Previous settled clock level
    logic       sdaLast_q;   // Previous settled data level

    // Two flops per line; only stage 1 is looked at
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sclSync_q <= 2'h3;
            sdaSync_q <= 2'h3;
            sclLast_q <= 1'b1;
            sdaLast_q <= 1'b1;
        end else begin
            sclSync_q <= {sclSync_q[0], sclIn};
            sdaSync_q <= {sdaSync_q[0], sdaIn};
            sclLast_q <= sclSync_q[1];
            sdaLast_q <= sdaSync_q[1];
        end
    end

    // Clock high on both samples guards against skew on edges
    wire sclHigh = sclSync_q[1] & sclLast_q;

    assign edges.sclRise = sclSync_q[1] & ~sclLast_q;
    assign edges.sclFall = ~sclSync_q[1] & sclLast_q;
    assign edges.start   = sclHigh & sdaLast_q & ~sdaSync_q[1];
    assign edges.stop    = sclHigh & ~sdaLast_q & sdaSync_q[1];
    assign edges.sda     = sdaSync_q[1];

endmodule

/* testbench/iist_top_chk.sv */
// Purpose: Port-level checks of the bus event timing block
// Assumes: One clock domain, asynchronous active-low reset
// Notes: Helper counters saturate so that old causes fade out
`timescale 1ns/1ps
module iist_top_chk
    import iist_pkg::*;
(
    // Clock and reset
    input logic        clk_sys,
    input logic        rst_n,
    // Lines and events
    input logic        sclIn,
    input logic        sdaIn,
    input logic        busEventRequest,
    input logic        irq,
    // Register bus
    input logic        s_axi_awvalid,
    input logic        s_axi_awready,
    input logic        s_axi_wvalid,
    input logic        s_axi_wready,
    input logic        s_axi_bvalid,
    input logic        s_axi_arvalid,
    input logic        s_axi_arready,
    input logic        s_axi_rvalid,
    input logic [1:0]  s_axi_rresp,
    input logic [31:0] s_axi_rdata
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // Cycles since a line edge, an event, a write
    logic [3:0] sinceLine_q, sinceEv_q, sinceWr_q;
    // Line levels one cycle ago
    logic       sclOld_q, sdaOld_q;
    // Age counters; a clock fall or data rise restarts the line count
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            {sinceLine_q, sinceEv_q, sinceWr_q} <= 12'hfff;
            {sclOld_q, sdaOld_q} <= 2'h3;
        end else begin
            sclOld_q <= sclIn;
            sdaOld_q <= sdaIn;
            sinceLine_q <= ((sclOld_q && !sclIn) || (!sdaOld_q && sdaIn)) ? 4'h0 :
                           (&sinceLine_q) ? sinceLine_q : sinceLine_q + 4'h1;
            sinceEv_q <= busEventRequest ? 4'h0 : (&sinceEv_q) ? sinceEv_q : sinceEv_q + 4'h1;
            sinceWr_q <= (s_axi_awvalid && s_axi_awready) ? 4'h0 :
                         (&sinceWr_q) ? sinceWr_q : sinceWr_q + 4'h1;
        end
    end
    // Both halves of a write taken together
    sequence wTake;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence arTake;
        s_axi_arvalid && s_axi_arready;
    endsequence
    AST_PULSE_ONE: assert property (busEventRequest |=> !busEventRequest)
        else $error("event request wider than one cycle");
    AST_EVT_CAUSE: assert property (busEventRequest |-> sinceLine_q <= 4'h9)
        else $error("event request without a line edge");
    AST_WR_ANSWER: assert property (wTake |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    AST_RD_ANSWER: assert property (arTake |=> s_axi_rvalid)
        else $error("read data late");
    AST_WR_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    AST_RD_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
    AST_RD_ERR_ZERO: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("error read returns data");
    AST_IRQ_RISE: assert property ($rose(irq) |-> sinceEv_q <= 4'h3 || sinceWr_q <= 4'h6)
        else $error("interrupt rose without cause");
    AST_IRQ_FALL: assert property ($fell(irq) |-> sinceWr_q <= 4'h6)
        else $error("interrupt fell without a write");
endmodule

/* testbench/iist_line_model.sv */
// Purpose: Bus lines as driven by the other parties of the link
// Assumes: Open-drain lines with pull-ups; idle level is high
// Notes: Clock stands still between frames; 8 system cycles a bit
`timescale 1ns/1ps
module iist_line_model (
    // Bench clock
    input  wire logic clk_sys,
    // Bus lines
    output logic      sclLine,
    output logic      sdaLine
);
    // Idle lines sit at the pull-up level
    initial begin
        sclLine = 1'b1;
        sdaLine = 1'b1;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // Data moves a cycle after the fall, never beside a clock edge
    task automatic bit_out(input logic b);
        wt(1);
        sdaLine <= b;
        wt(3);
        sclLine <= 1'b1;
        wt(4);
        sclLine <= 1'b0;
    endtask
    // Start or restart: data falls while the clock is high
    task automatic frame_start;
        bit_out(1'b1);
        wt(1);
        sclLine <= 1'b1;
        wt(4);
        sdaLine <= 1'b0;
        wt(4);
        sclLine <= 1'b0;
    endtask
    // Eight bits MSB first, then the acknowledge clock
    task automatic send_byte(input logic [7:0] b, input logic ackLow);
        for (int i = 7; i >= 0; i--) bit_out(b[i]);
        bit_out(!ackLow);
        wt(1);
        sdaLine <= 1'b1;
    endtask
    // Stop: data rises while the clock is high
    task automatic frame_stop;
        bit_out(1'b0);
        wt(1);
        sclLine <= 1'b1;
        wt(4);
        sdaLine <= 1'b1;
        wt(4);
    endtask
endmodule

/* testbench/iist_top_bench.sv */
// Purpose: Self-checking bench of the bus event timing block
// Assumes: 100 ns system clock, 800 ns bus clock from the line model
// Notes: Status read back after each byte; don't-care bits masked
`timescale 1ns/1ps
module iist_top_bench
    import iist_pkg::*;
;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic        sclIn, sdaIn, busEventRequest, irq;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    int          nErrors = 0, nChecks = 0, nEv = 0;
    always #50 clk_sys = ~clk_sys;
    // Count event pulses as they pass
    always @(posedge clk_sys) if (busEventRequest === 1'b1) nEv++;
    iist_top i_dut (.*);
    iist_line_model i_line (.clk_sys(clk_sys), .sclLine(sclIn), .sdaLine(sdaIn));
    task automatic give_verdict;
        $display("checks %0d errors %0d", nChecks, nErrors);
        if (nErrors == 0 && nChecks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic check_val(input logic [31:0] got, exp);
        nChecks++;
        if (got !== exp) begin
            nErrors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Status compare; set bits of dc are don't care
    task automatic check_stat(input logic [7:0] got, exp, dc);
        nChecks++;
        if ((got & ~dc) !== (exp & ~dc)) begin
            nErrors++;
            $display("wrong value at %0t: status %h expected %h", $time, got, exp);
        end
    endtask
    // Address and data offered together, held until each is taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
        do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axr(input logic [7:0] a);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // One byte or a stop, then event count and status snapshot
    task automatic step(input bit isStop, input logic [7:0] b, input int nExp, input logic [7:0] exp, dc);
        int e0;
        e0 = nEv;
        if (isStop) i_line.frame_stop();
        else i_line.send_byte(b, 1'b1);
        repeat (10) @(posedge clk_sys);
        check_val(32'(nEv - e0), 32'(nExp));
        axr(STATUS_OFS);
        check_stat(rd[7:0], exp, dc);
    endtask
    task automatic sc_regs;
        axr(CTRL_OFS);
        check_val(rd, 32'(CTRL_RST));
        axr(STATUS_OFS);
        check_val(rd, 32'(STATUS_RST));
        axr(8'h40);
        check_val({rd[31:2], rsp}, {30'h0, RESP_SLVERR});
        axw(8'h44, 32'h1);
        check_val(32'(rsp), 32'(RESP_SLVERR));
    endtask
    // Master, eighth-clock wait, stop event enabled
    task automatic sc_master8;
        axw(CTRL_OFS, 32'h6);
        i_line.frame_start();
        step(0, 8'ha0, 1, 8'h86, 8'h08);
        step(0, 8'h55, 1, 8'h80, 8'h08);
        axw(CTRL_OFS, 32'h7);
        step(0, 8'h3c, 1, 8'h80, 8'h0c);
        step(1, 8'h00, 1, STOP_STATUS, 8'h00);
    endtask
    // Master, ninth-clock wait, stop event disabled
    task automatic sc_master9;
        axw(CTRL_OFS, 32'h5);
        i_line.frame_start();
        step(0, 8'ha0, 1, 8'h86, 8'h08);
        step(0, 8'h12, 1, 8'h84, 8'h08);
        step(0, 8'h34, 1, 8'h80, 8'h0c);
        step(1, 8'h00, 0, STOP_STATUS, 8'h00);
    endtask
    task automatic sc_master_ext;
        axw(CTRL_OFS, 32'h6);
        i_line.frame_start();
        step(0, 8'h04, 1, 8'ha6, 8'h08);
        step(0, 8'h77, 1, 8'ha0, 8'h08);
        axw(CTRL_OFS, 32'h7);
        step(0, 8'h88, 1, 8'ha4, 8'h08);
        step(0, 8'h99, 1, 8'ha0, 8'h0c);
        step(1, 8'h00, 1, STOP_STATUS, 8'h00);
    endtask
    // Slave: extension code, restart with another code
    task automatic sc_slave_ext;
        axw(CTRL_OFS, 32'h2);
        i_line.frame_start();
        step(0, 8'hf0, 1, 8'h22, 8'h08);
        step(0, 8'h5a, 1, 8'h20, 8'h08);
        axw(CTRL_OFS, 32'h3);
        i_line.frame_start();
        step(0, 8'h02, 2, 8'h26, 8'h08);
        step(0, 8'ha5, 1, 8'h20, 8'h0c);
        step(1, 8'h00, 1, STOP_STATUS, 8'h00);
        // Ordinary address as slave raises nothing
        i_line.frame_start();
        step(0, 8'ha0, 0, STOP_STATUS, 8'h00);
        step(1, 8'h00, 1, STOP_STATUS, 8'h00);
    endtask
    task automatic sc_irq;
        axw(INTST_OFS, 32'h1);
        axw(INTMSK_OFS, 32'h1);
        axw(CTRL_OFS, 32'h6);
        i_line.frame_start();
        step(0, 8'ha0, 1, 8'h86, 8'h08);
        check_val(32'(irq), 32'h1);
        axw(INTST_OFS, 32'h1);
        repeat (3) @(posedge clk_sys);
        check_val(32'(irq), 32'h0);
        axw(INTMSK_OFS, 32'h0);
        step(1, 8'h00, 1, STOP_STATUS, 8'h00);
        check_val(32'(irq), 32'h0);
        axr(INTST_OFS);
        check_val(rd, 32'h1);
    endtask
    initial begin
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        sc_regs();
        sc_master8();
        sc_master9();
        sc_master_ext();
        sc_slave_ext();
        sc_irq();
        give_verdict();
    end
    // Whole run needs about 1800 cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        nErrors++;
        $display("wrong value at %0t: run timed out", $time);
        give_verdict();
    end
endmodule
bind iist_top iist_top_chk u_chk (.*);
